// ==== rtl/hdm_monitor.sv ====
// harmonic distortion alarm monitor top
`timescale 1ns/1ps
module hdm_monitor #(
	parameter int MS_CYCLES = hdm_pkg::MS_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic spec_valid,
	input wire logic [2:0] spec_chan,
	input wire logic [4:0] spec_harm,
	input wire logic [15:0] spec_mag,
	input wire logic blk_in,
	input wire logic [2:0] sg_active,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic [2:0] elem_start,
	output logic [2:0] elem_alarm,
	output logic blocked,
	output logic [1:0] monitor_state_code,
	output logic evt_valid,
	output logic [2:0] evt_id,
	output logic evt_on,
	output logic [31:0] evt_time
);
	typedef struct packed {
		logic [31:0] ctrl;
		logic [2:0][13:0] lim;
		logic [2:0][18:0] dly;
		logic [4:0][15:0] thd;
		logic blk_smp;
		logic eval;
		logic [2:0] pu;
		logic [2:0] start;
		logic [2:0] alarm;
		logic blocked;
		logic [2:0][21:0] tmr;
		logic [16:0] ms_div;
		logic [31:0] ts;
		logic [13:0] evt_pend;
		logic [6:0] log_pend;
		logic [11:0] log_dummy;
		logic [3:0] log_wp;
		logic [3:0] log_cnt;
		logic [3:0] log_sel;
		logic evt_valid;
		logic [2:0] evt_id;
		logic evt_on;
		logic [31:0] evt_ts;
		logic [31:0] rdata;
		hdm_pkg::hdm_state_t state;
	} hdm_regs_t;

	hdm_regs_t r, n;
	hdm_pkg::hdm_log_t [hdm_pkg::LOG_DEPTH-1:0] log_r, log_nxt;
	logic rat_done;
	logic [2:0] rat_chan;
	logic [15:0] rat_val;

	function automatic logic [3:0] first_set(input logic [13:0] v);
		logic [3:0] idx;
		idx = '0;
		for (int i = 13; i >= 0; i--) begin
			if (v[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction

	function automatic logic over_f(input logic [15:0] t, input logic [13:0] l);
		return t > {2'b00, l};
	endfunction

	function automatic logic under_f(input logic [15:0] t, input logic [13:0] l);
		return 32'(t) * 32'(hdm_pkg::HYST_DEN) < 32'(l) * 32'(hdm_pkg::HYST_NUM);
	endfunction

	////////////////////////////////////////////////////////////////
	hdm_ratio u_ratio (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.in_valid(spec_valid),
		.in_chan(spec_chan),
		.in_harm(spec_harm),
		.in_mag(spec_mag),
		.meth(r.ctrl[hdm_pkg::CTRL_METH +: 2]),
		.out_done(rat_done),
		.out_chan(rat_chan),
		.out_ratio(rat_val)
	);

	////////////////////////////////////////////////////////////////
	always_comb begin
		logic ms_tick;
		logic [2:0] ov;
		logic [2:0] un;
		logic [21:0] dly_ms;
		logic [6:0] ev_on;
		logic [6:0] ev_off;
		logic [3:0] idx;
		logic [4:0] lidx;
		logic [31:0] d;
		hdm_pkg::hdm_log_t e;
		ms_tick = r.ms_div == 17'(MS_CYCLES - 1);
		ov = '0;
		un = '0;
		dly_ms = '0;
		idx = '0;
		d = '0;
		ev_on = '0;
		ev_off = '0;
		lidx = '0;
		e = '0;
		n = r;
		log_nxt = log_r;
		n.evt_valid = 1'b0;
		n.rdata = '0;
		n.eval = 1'b0;
		// millisecond time base
		n.ms_div = ms_tick ? '0 : r.ms_div + 17'h0_0001;
		if (ms_tick) begin
			n.ts = r.ts + 32'h0000_0001;
		end
		// measured ratios, evaluation after last channel
		if (rat_done && rat_chan < 3'(hdm_pkg::NCHAN)) begin
			n.thd[rat_chan] = rat_val;
			n.eval = rat_chan == 3'(hdm_pkg::NCHAN - 1);
		end
		if (spec_valid && spec_harm == hdm_pkg::HARM_FUND && spec_chan == 3'h0) begin
			n.blk_smp = r.ctrl[hdm_pkg::CTRL_FMODE] ? r.ctrl[hdm_pkg::CTRL_FBLK] : blk_in;
		end
		// pick-up, hysteresis and blocking
		if (r.eval) begin
			ov[0] = over_f(r.thd[0], r.lim[0]) | over_f(r.thd[1], r.lim[0]) | over_f(r.thd[2], r.lim[0]);
			un[0] = under_f(r.thd[0], r.lim[0]) & under_f(r.thd[1], r.lim[0]) & under_f(r.thd[2], r.lim[0]);
			ov[1] = over_f(r.thd[3], r.lim[1]);
			un[1] = under_f(r.thd[3], r.lim[1]);
			ov[2] = over_f(r.thd[4], r.lim[2]);
			un[2] = under_f(r.thd[4], r.lim[2]);
			for (int k = 0; k < hdm_pkg::NEL; k++) begin
				n.pu[k] = !r.ctrl[hdm_pkg::CTRL_DIS + k] && (ov[k] || (r.pu[k] && !un[k]));
				n.start[k] = n.pu[k] && !r.blk_smp;
			end
			n.blocked = r.blk_smp && (|n.pu);
		end
		// definite delay timers
		for (int k = 0; k < hdm_pkg::NEL; k++) begin
			dly_ms = 22'(r.dly[k]) * 22'(hdm_pkg::DLY_STEP_MS);
			if (!r.start[k]) begin
				n.tmr[k] = '0;
			end else if (ms_tick && r.tmr[k] < dly_ms) begin
				n.tmr[k] = r.tmr[k] + 22'h00_0001;
			end
			n.alarm[k] = n.start[k] && r.start[k] && r.tmr[k] >= dly_ms;
		end
		// status code
		if (n.blocked) begin
			n.state = hdm_pkg::HDM_BLOCKED;
		end else if (|n.alarm) begin
			n.state = hdm_pkg::HDM_ALARM;
		end else if (|n.start) begin
			n.state = hdm_pkg::HDM_START;
		end else begin
			n.state = hdm_pkg::HDM_NORMAL;
		end
		// events
		ev_on = {n.blocked & ~r.blocked, n.alarm & ~r.alarm, n.start & ~r.start};
		ev_off = {~n.blocked & r.blocked, ~n.alarm & r.alarm, ~n.start & r.start};
		if (|r.evt_pend) begin
			idx = first_set(r.evt_pend);
			n.evt_valid = 1'b1;
			n.evt_on = idx < 4'(hdm_pkg::NEVT);
			n.evt_id = (idx < 4'(hdm_pkg::NEVT)) ? idx[2:0] : 3'(idx - 4'(hdm_pkg::NEVT));
			n.evt_ts = r.ts;
			n.evt_pend[idx] = 1'b0;
		end
		n.evt_pend = n.evt_pend | {ev_off & {hdm_pkg::NEVT{r.ctrl[hdm_pkg::CTRL_EV_OFF]}},
			ev_on & {hdm_pkg::NEVT{r.ctrl[hdm_pkg::CTRL_EV_ON]}}};
		// rolling log of on events
		if (|r.log_pend) begin
			idx = first_set({7'h00, r.log_pend});
			log_nxt[r.log_wp] = {r.ts, idx[2:0], r.pu, sg_active, r.thd[2], r.thd[1], r.thd[0]};
			n.log_wp = (r.log_wp == 4'(hdm_pkg::LOG_DEPTH - 1)) ? 4'h0 : r.log_wp + 4'h1;
			if (r.log_cnt < 4'(hdm_pkg::LOG_DEPTH)) begin
				n.log_cnt = r.log_cnt + 4'h1;
			end
			n.log_pend[idx[2:0]] = 1'b0;
		end
		n.log_pend = n.log_pend | ev_on;
		// register writes
		if (reg_wr) begin
			case (reg_addr)
				hdm_pkg::REG_CTRL: n.ctrl = reg_wdata & 32'h0000_01ff;
				hdm_pkg::REG_PH_LIM: n.lim[0] = reg_wdata[13:0];
				hdm_pkg::REG_R1_LIM: n.lim[1] = reg_wdata[13:0];
				hdm_pkg::REG_R2_LIM: n.lim[2] = reg_wdata[13:0];
				hdm_pkg::REG_PH_DLY: n.dly[0] = reg_wdata[18:0];
				hdm_pkg::REG_R1_DLY: n.dly[1] = reg_wdata[18:0];
				hdm_pkg::REG_R2_DLY: n.dly[2] = reg_wdata[18:0];
				hdm_pkg::REG_LOG_SEL: n.log_sel = (reg_wdata < 32'(hdm_pkg::LOG_DEPTH)) ? reg_wdata[3:0]
					: 4'(hdm_pkg::LOG_DEPTH - 1);
				default: n.ctrl = n.ctrl;
			endcase
		end
		// register reads, newest log entry at index zero
		lidx = 5'(r.log_wp) + 5'(hdm_pkg::LOG_DEPTH - 1) - 5'(r.log_sel);
		if (lidx >= 5'(hdm_pkg::LOG_DEPTH)) begin
			lidx = lidx - 5'(hdm_pkg::LOG_DEPTH);
		end
		e = log_r[lidx[3:0]];
		case (reg_addr)
			hdm_pkg::REG_CTRL: d = r.ctrl;
			hdm_pkg::REG_PH_LIM: d = 32'(r.lim[0]);
			hdm_pkg::REG_R1_LIM: d = 32'(r.lim[1]);
			hdm_pkg::REG_R2_LIM: d = 32'(r.lim[2]);
			hdm_pkg::REG_PH_DLY: d = 32'(r.dly[0]);
			hdm_pkg::REG_R1_DLY: d = 32'(r.dly[1]);
			hdm_pkg::REG_R2_DLY: d = 32'(r.dly[2]);
			hdm_pkg::REG_STATUS: d = 32'({r.log_cnt, r.blk_smp, r.blocked, r.alarm, r.start, r.state});
			hdm_pkg::REG_THD01: d = {r.thd[1], r.thd[0]};
			hdm_pkg::REG_THD23: d = {r.thd[3], r.thd[2]};
			hdm_pkg::REG_THD4: d = 32'(r.thd[4]);
			hdm_pkg::REG_LOG_SEL: d = 32'(r.log_sel);
			hdm_pkg::REG_LOG_TIME: d = e.ts;
			hdm_pkg::REG_LOG_INFO: d = 32'({e.sg, e.ftype, e.id});
			hdm_pkg::REG_LOG_THD01: d = {e.thd[1], e.thd[0]};
			hdm_pkg::REG_LOG_THD2: d = 32'(e.thd[2]);
			default: d = '0;
		endcase
		if (reg_rd) begin
			n.rdata = d;
		end
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			r <= '0;
			r.ctrl <= hdm_pkg::CTRL_RST;
			r.lim <= {3{hdm_pkg::LIM_RST}};
			r.dly <= {3{hdm_pkg::DLY_RST}};
			r.state <= hdm_pkg::HDM_NORMAL;
			log_r <= '0;
		end else begin
			r <= n;
			log_r <= log_nxt;
		end
	end

	assign reg_rdata = r.rdata;
	assign elem_start = r.start;
	assign elem_alarm = r.alarm;
	assign blocked = r.blocked;
	assign monitor_state_code = r.state;
	assign evt_valid = r.evt_valid;
	assign evt_id = r.evt_id;
	assign evt_on = r.evt_on;
	assign evt_time = r.evt_ts;
endmodule // hdm_monitor

// ==== rtl/hdm_pkg.sv ====
// constants, types and field layout of the harmonic distortion alarm monitor
package hdm_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int TS_RES_MS = 1;
	localparam int MS_CYCLES = TS_RES_MS * 1000000 / CLK_PERIOD_NS;
	localparam int DLY_STEP_MS = 5;
	localparam int RATIO_SCALE = 10000;
	localparam int HYST_NUM = 97;
	localparam int HYST_DEN = 100;
	localparam int NCHAN = 5;
	localparam int NEL = 3;
	localparam int NEVT = 7;
	localparam int LOG_DEPTH = 12;
	localparam logic [4:0] HARM_FUND = 5'h01;
	localparam logic [4:0] HARM_LAST = 5'h1f;
	localparam logic [1:0] METH_AMP = 2'h1;
	localparam logic [1:0] METH_PWR = 2'h2;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_PH_LIM = 4'h1;
	localparam logic [3:0] REG_R1_LIM = 4'h2;
	localparam logic [3:0] REG_R2_LIM = 4'h3;
	localparam logic [3:0] REG_PH_DLY = 4'h4;
	localparam logic [3:0] REG_R1_DLY = 4'h5;
	localparam logic [3:0] REG_R2_DLY = 4'h6;
	localparam logic [3:0] REG_STATUS = 4'h7;
	localparam logic [3:0] REG_THD01 = 4'h8;
	localparam logic [3:0] REG_THD23 = 4'h9;
	localparam logic [3:0] REG_THD4 = 4'ha;
	localparam logic [3:0] REG_LOG_SEL = 4'hb;
	localparam logic [3:0] REG_LOG_TIME = 4'hc;
	localparam logic [3:0] REG_LOG_INFO = 4'hd;
	localparam logic [3:0] REG_LOG_THD01 = 4'he;
	localparam logic [3:0] REG_LOG_THD2 = 4'hf;
	localparam int CTRL_METH = 0;
	localparam int CTRL_DIS = 2;
	localparam int CTRL_EV_ON = 5;
	localparam int CTRL_EV_OFF = 6;
	localparam int CTRL_FMODE = 7;
	localparam int CTRL_FBLK = 8;
	localparam logic [31:0] CTRL_RST = 32'h0000_0061;
	localparam logic [13:0] LIM_RST = 14'h03e8;
	localparam logic [18:0] DLY_RST = 19'h0_07d0;
	typedef enum logic [1:0] {
		HDM_NORMAL = 2'b00,
		HDM_START = 2'b01,
		HDM_ALARM = 2'b10,
		HDM_BLOCKED = 2'b11
	} hdm_state_t;
	typedef struct packed {
		logic [31:0] ts;
		logic [2:0] id;
		logic [2:0] ftype;
		logic [2:0] sg;
		logic [2:0][15:0] thd;
	} hdm_log_t;
endpackage

// ==== rtl/hdm_ratio.sv ====
// distortion ratio from a streamed harmonic spectrum
`timescale 1ns/1ps
module hdm_ratio (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic in_valid,
	input wire logic [2:0] in_chan,
	input wire logic [4:0] in_harm,
	input wire logic [15:0] in_mag,
	input wire logic [1:0] meth,
	output logic out_done,
	output logic [2:0] out_chan,
	output logic [15:0] out_ratio
);
	typedef struct packed {
		logic [36:0] sum;
		logic [15:0] fund;
		logic calc;
		logic [2:0] chan;
		logic done;
		logic [15:0] ratio;
	} hdm_ratio_st_t;

	hdm_ratio_st_t r, n;

	function automatic logic [18:0] isqrt(input logic [36:0] v);
		logic [18:0] res;
		logic [18:0] t;
		res = '0;
		for (int i = 18; i >= 0; i--) begin
			t = res | (19'h0_0001 << i);
			if ({19'h0_0000, t} * {19'h0_0000, t} <= {1'b0, v}) begin
				res = t;
			end
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////
	always_comb begin
		logic [63:0] num;
		logic [63:0] den;
		logic [63:0] q;
		num = '0;
		den = '0;
		q = '0;
		n = r;
		n.done = 1'b0;
		if (r.calc) begin
			if (meth == hdm_pkg::METH_PWR) begin
				num = 64'(r.sum) * 64'(hdm_pkg::RATIO_SCALE);
				den = 64'(r.fund) * 64'(r.fund);
			end else begin
				num = 64'(isqrt(r.sum)) * 64'(hdm_pkg::RATIO_SCALE);
				den = 64'(r.fund);
			end
			q = (den == '0) ? '1 : num / den;
			n.ratio = (q > 64'h0000_0000_0000_ffff) ? 16'hffff : q[15:0];
			n.done = 1'b1;
			n.calc = 1'b0;
		end
		if (in_valid) begin
			if (in_harm == hdm_pkg::HARM_FUND) begin
				n.fund = in_mag;
				n.sum = '0;
			end else if (in_harm != 5'h00) begin
				n.sum = r.sum + 37'(32'(in_mag) * 32'(in_mag));
			end
			if (in_harm == hdm_pkg::HARM_LAST) begin
				n.calc = 1'b1;
				n.chan = in_chan;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign out_done = r.done;
	assign out_chan = r.chan;
	assign out_ratio = r.ratio;
endmodule // hdm_ratio

// ==== verif/hdm_checker.sv ====
// port assertions of the distortion monitor
`timescale 1ns/1ps
module hdm_checker #(
	parameter int MS_CYCLES = 100000
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [2:0] elem_start,
	input wire logic [2:0] elem_alarm,
	input wire logic blocked,
	input wire logic [1:0] monitor_state_code,
	input wire logic evt_valid,
	input wire logic [2:0] evt_id,
	input wire logic evt_on
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////
	chk_state_blk: assert property (blocked |-> monitor_state_code == 2'h3)
		else $error("state code not blocked");
	chk_state_alarm: assert property ((!blocked && |elem_alarm) |-> monitor_state_code == 2'h2)
		else $error("state code not alarm");
	chk_state_start: assert property ((!blocked && !(|elem_alarm) && |elem_start) |-> monitor_state_code == 2'h1)
		else $error("state code not start");
	chk_state_idle: assert property ((!blocked && elem_start == 3'h0) |-> monitor_state_code == 2'h0)
		else $error("state code not normal");
	chk_alarm_start: assert property ((elem_alarm & ~elem_start) == 3'h0)
		else $error("alarm without start");
	chk_blk_start: assert property (blocked |-> elem_start == 3'h0)
		else $error("start while blocked");
	chk_ev_start: assert property ($rose(elem_start[0]) |-> ##[0:16] (evt_valid && evt_on && evt_id == 3'h0))
		else $error("no start on event");
	chk_ev_off: assert property ($fell(elem_start[0]) |-> ##[0:16] (evt_valid && !evt_on && evt_id == 3'h0))
		else $error("no start off event");
	chk_ev_alarm: assert property ($rose(elem_alarm[0]) |-> ##[0:16] (evt_valid && evt_on && evt_id == 3'h3))
		else $error("no alarm on event");
	chk_ev_blk: assert property ($rose(blocked) |-> ##[0:16] (evt_valid && evt_on && evt_id == 3'h6))
		else $error("no blocked on event");
	cov_alarm: cover property ($rose(elem_alarm[0]));
	cov_blk: cover property ($rose(blocked));
	cov_off: cover property (evt_valid && !evt_on);
endmodule // hdm_checker
bind hdm_monitor hdm_checker #(.MS_CYCLES(MS_CYCLES)) i_chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.elem_start(elem_start), .elem_alarm(elem_alarm), .blocked(blocked),
	.monitor_state_code(monitor_state_code), .evt_valid(evt_valid), .evt_id(evt_id), .evt_on(evt_on));

// ==== verif/hdm_spec_src.sv ====
// spectrum source, one program cycle per request
`timescale 1ns/1ps
module hdm_spec_src #(
	parameter logic [15:0] FUND = 16'h03e8
) (
	input wire logic clk_sys,
	input wire logic go,
	input wire logic [4:0][15:0] h2,
	output logic spec_valid,
	output logic [2:0] spec_chan,
	output logic [4:0] spec_harm,
	output logic [15:0] spec_mag,
	output logic busy
);
	initial begin
		spec_valid = 1'b0;
		spec_chan = 3'h0;
		spec_harm = 5'h00;
		spec_mag = 16'h5a5a;
		busy = 1'b0;
	end
	always @(posedge clk_sys) begin
		if (go) begin
			busy <= 1'b1;
			for (int c = 0; c < 5; c++) begin
				for (int h = 1; h < 32; h++) begin
					spec_valid <= 1'b1;
					spec_chan <= c[2:0];
					spec_harm <= h[4:0];
					spec_mag <= (h == 1) ? FUND : ((h == 2) ? h2[c] : 16'h0000);
					@(posedge clk_sys);
				end
			end
			spec_valid <= 1'b0;
			busy <= 1'b0;
		end else begin
			// idle magnitude and channel lines never hold old data; spec_valid and spec_harm keep their values
			spec_mag <= ~spec_mag;
			spec_chan <= spec_chan + 3'h1;
		end
	end
endmodule // hdm_spec_src

// ==== verif/harmonic_distortion_alarm_monitor_tb_top.sv ====
// self-checking bench of the distortion monitor
`timescale 1ns/1ps
module harmonic_distortion_alarm_monitor_tb_top;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic go = 1'b0;
	logic blk_in = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [2:0] sg_active = 3'h0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic [4:0][15:0] h2 = '0;
	logic spec_valid, busy, blocked, evt_valid, evt_on;
	logic [2:0] spec_chan, elem_start, elem_alarm, evt_id, pk, st_prev, sg;
	logic [4:0] spec_harm;
	logic [15:0] spec_mag;
	logic [1:0] monitor_state_code;
	logic [31:0] reg_rdata, evt_time, ctrl, d;
	int miscompares = 0;
	int n_compared = 0;
	int seed = 32'hd5eb;
	int lims[3] = '{1000, 1000, 1050};
	int corner[4] = '{101, 97, 96, 100};
	always #5 clk_sys = ~clk_sys;
	hdm_monitor #(.MS_CYCLES(10)) i_dut (.clk_sys, .rst_n, .spec_valid, .spec_chan, .spec_harm, .spec_mag, .blk_in,
		.sg_active, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .elem_start, .elem_alarm, .blocked,
		.monitor_state_code, .evt_valid, .evt_id, .evt_on, .evt_time);
	hdm_spec_src i_src (.clk_sys, .go, .h2, .spec_valid, .spec_chan, .spec_harm, .spec_mag, .busy);
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		if (miscompares == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask
	task automatic setc(input logic [31:0] v);
		ctrl = v;
		wr(hdm_pkg::REG_CTRL, v);
	endtask
	// one program cycle; fundamental is 1000 in the source
	task automatic frame(input logic b);
		int r[5];
		int rr[3];
		int n;
		logic blk;
		logic [2:0] st;
		for (int c = 0; c < 5; c++) begin
			r[c] = (ctrl[1:0] == hdm_pkg::METH_PWR) ? int'(h2[c]) * int'(h2[c]) / 100 : int'(h2[c]) * 10;
		end
		rr[0] = (r[0] > r[1]) ? r[0] : r[1];
		rr[0] = (rr[0] > r[2]) ? rr[0] : r[2];
		rr[1] = r[3];
		rr[2] = r[4];
		for (int e = 0; e < 3; e++) begin
			pk[e] = !ctrl[hdm_pkg::CTRL_DIS + e] && (pk[e] ? rr[e] * 100 >= lims[e] * 97 : rr[e] > lims[e]);
		end
		blk = b | (ctrl[hdm_pkg::CTRL_FMODE] & ctrl[hdm_pkg::CTRL_FBLK]);
		st = blk ? 3'h0 : pk;
		sg = 3'($random(seed));
		@(posedge clk_sys);
		blk_in <= b;
		sg_active <= sg;
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (busy && n < 400);
		if (busy) begin
			miscompares++;
			$display("unexpected at %0t: spectrum source hung", $time);
			report_and_stop();
		end
		repeat (5) @(posedge clk_sys);
		#1;
		check({blocked, elem_alarm, elem_start}, {blk & |pk, st & st_prev, st});
		check(32'(monitor_state_code), (blk & |pk) ? 32'h0000_0003 : (|(st & st_prev) ? 32'h0000_0002
			: (|st ? 32'h0000_0001 : 32'h0000_0000)));
		st_prev = st;
		rd(hdm_pkg::REG_THD01, d);
		check(d, {16'(r[1]), 16'(r[0])});
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] dflt[7];
		pk = 3'h0;
		st_prev = 3'h0;
		ctrl = hdm_pkg::CTRL_RST;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		dflt = '{hdm_pkg::CTRL_RST, 32'(hdm_pkg::LIM_RST), 32'(hdm_pkg::LIM_RST), 32'(hdm_pkg::LIM_RST),
			32'(hdm_pkg::DLY_RST), 32'(hdm_pkg::DLY_RST), 32'(hdm_pkg::DLY_RST)};
		for (int a = 0; a < 7; a++) begin
			rd(4'(a), d);
			check(d, dflt[a]);
		end
		wr(hdm_pkg::REG_STATUS, 32'hffff_ffff);
		rd(hdm_pkg::REG_STATUS, d);
		check(d, 32'h0000_0000);
		for (int a = 4; a < 7; a++) begin
			wr(4'(a), 32'h0000_0001);
		end
		wr(hdm_pkg::REG_R2_LIM, 32'h0000_041a);
		foreach (corner[i]) begin
			h2 = {5{16'h0032}};
			h2[0] = 16'(corner[i]);
			frame(1'b0);
		end
		for (int k = 0; k < 16; k++) begin
			if (k == 8) begin
				setc(32'h0000_0072);
			end
			for (int c = 0; c < 5; c++) begin
				h2[c] = 16'((k < 8 ? 90 : 300) + $unsigned($random(seed)) % (k < 8 ? 25 : 30));
			end
			frame(1'b0);
		end
		setc(hdm_pkg::CTRL_RST);
		h2 = {5{16'h006e}};
		frame(1'b0);
		frame(1'b1);
		wr(hdm_pkg::REG_LOG_SEL, 32'h0000_0000);
		rd(hdm_pkg::REG_LOG_INFO, d);
		check(d, {23'h0, sg, pk, 3'h6});
		h2 = {5{16'h0032}};
		frame(1'b0);
		setc(32'h0000_01e1);
		h2 = {5{16'h006e}};
		frame(1'b0);
		report_and_stop();
	end
endmodule // harmonic_distortion_alarm_monitor_tb_top
